/* psm_defines.vh */
/*
 * Shared constants of the packed multiply, dot product, blend and
 * min/max datapath: operation codes and exception flag positions.
 * Assumes inclusion by bare name from every design file.
 */
`ifndef PSM_DEFINES_VH
`define PSM_DEFINES_VH

// Operation codes
`define PSM_OP_W 5
`define PSM_OP_MUL_SIGNED_LOW_DWORD 5'h00
`define PSM_OP_MUL_SIGNED_WIDE_DWORD 5'h01
`define PSM_OP_MUL_UNSIGNED_WIDE_DWORD 5'h02
`define PSM_OP_DOT_PRODUCT_SINGLE 5'h03
`define PSM_OP_DOT_PRODUCT_DOUBLE 5'h04
`define PSM_OP_BLEND_SINGLE_BY_IMMEDIATE 5'h05
`define PSM_OP_BLEND_DOUBLE_BY_IMMEDIATE 5'h06
`define PSM_OP_BLEND_WORD_BY_IMMEDIATE 5'h07
`define PSM_OP_BLEND_SINGLE_BY_REGISTER 5'h08
`define PSM_OP_BLEND_DOUBLE_BY_REGISTER 5'h09
`define PSM_OP_BLEND_BYTE_BY_REGISTER 5'h0A
`define PSM_OP_MIN_UNSIGNED_WORD 5'h0B
`define PSM_OP_MIN_UNSIGNED_DWORD 5'h0C
`define PSM_OP_MIN_SIGNED_BYTE 5'h0D
`define PSM_OP_MIN_SIGNED_DWORD 5'h0E
`define PSM_OP_MAX_UNSIGNED_WORD 5'h0F
`define PSM_OP_MAX_UNSIGNED_DWORD 5'h10
`define PSM_OP_MAX_SIGNED_BYTE 5'h11
`define PSM_OP_MAX_SIGNED_DWORD 5'h12

// Floating-point exception flag positions
`define PSM_EXC_W 5
`define PSM_EXC_INVALID 0
`define PSM_EXC_DENORMAL 1
`define PSM_EXC_OVERFLOW 2
`define PSM_EXC_UNDERFLOW 3
`define PSM_EXC_INEXACT 4

// Result latency in core clock cycles
`define PSM_LATENCY 1

`endif

/* psm_fp_mul.v */
/*
 * Combinational floating-point multiply, width set by parameters.
 * Assumes round to nearest even; denormal inputs read as zero and
 * tiny results flush to zero.
 */
`timescale 1ns/1ps
`include "psm_defines.vh"

module psm_fp_mul #(
    parameter EW = 8,
    parameter MW = 23
)(
    input wire [EW+MW:0] a_in,
    input wire [EW+MW:0] b_in,
    output reg [EW+MW:0] p_out,
    output reg [`PSM_EXC_W-1:0] exc_out
);
    localparam [EW-1:0] EMAX = {EW{1'h1}};
    localparam [EW+1:0] BIAS = {3'h0, {(EW-1){1'h1}}};
    localparam [EW+MW:0] QBIT = {{(EW+1){1'h0}}, 1'h1, {(MW-1){1'h0}}};
    localparam [EW+MW:0] DNAN = {1'h1, EMAX, 1'h1, {(MW-1){1'h0}}};
    wire s = a_in[EW+MW] ^ b_in[EW+MW];
    wire [EW-1:0] ea = a_in[EW+MW-1:MW];
    wire [EW-1:0] eb = b_in[EW+MW-1:MW];
    wire [MW-1:0] fa = a_in[MW-1:0];
    wire [MW-1:0] fb = b_in[MW-1:0];
    wire nan_a = (ea == EMAX) && (fa != 0);
    wire nan_b = (eb == EMAX) && (fb != 0);
    wire inf_a = (ea == EMAX) && (fa == 0);
    wire inf_b = (eb == EMAX) && (fb == 0);
    wire zro_a = (ea == 0);
    wire zro_b = (eb == 0);
    wire den = (zro_a && (fa != 0)) || (zro_b && (fb != 0));
    wire snan = (nan_a && !fa[MW-1]) || (nan_b && !fb[MW-1]);
    wire [2*MW+1:0] prod = {1'h1, fa} * {1'h1, fb};
    reg [MW+1:0] m;
    reg [EW+1:0] e;
    reg g;
    reg st;

    always @*
    begin
        e = {2'h0, ea} + {2'h0, eb} - BIAS;
        if (prod[2*MW+1])
        begin
            m = {1'h0, prod[2*MW+1:MW+1]};
            g = prod[MW];
            st = |prod[MW-1:0];
            e = e + 1'h1;
        end
        else
        begin
            m = {1'h0, prod[2*MW:MW]};
            g = prod[MW-1];
            st = |prod[MW-2:0];
        end
        m = m + {{(MW+1){1'h0}}, g & (st | m[0])};
        if (m[MW+1])
        begin
            m = m >> 1;
            e = e + 1'h1;
        end
        exc_out = {`PSM_EXC_W{1'h0}};
        exc_out[`PSM_EXC_DENORMAL] = den;
        if (nan_a || nan_b)
        begin
            p_out = nan_a ? (a_in | QBIT) : (b_in | QBIT);
            exc_out[`PSM_EXC_INVALID] = snan;
        end
        else if ((inf_a && zro_b) || (inf_b && zro_a))
        begin
            p_out = DNAN;
            exc_out[`PSM_EXC_INVALID] = 1'h1;
        end
        else if (inf_a || inf_b)
            p_out = {s, EMAX, {MW{1'h0}}};
        else if (zro_a || zro_b)
            p_out = {s, {(EW+MW){1'h0}}};
        else if (e[EW+1] || (e == 0))
        begin
            p_out = {s, {(EW+MW){1'h0}}};
            exc_out[`PSM_EXC_UNDERFLOW] = 1'h1;
            exc_out[`PSM_EXC_INEXACT] = 1'h1;
        end
        else if (e[EW:0] >= {1'h0, EMAX})
        begin
            p_out = {s, EMAX, {MW{1'h0}}};
            exc_out[`PSM_EXC_OVERFLOW] = 1'h1;
            exc_out[`PSM_EXC_INEXACT] = 1'h1;
        end
        else
        begin
            p_out = {s, e[EW-1:0], m[MW-1:0]};
            exc_out[`PSM_EXC_INEXACT] = g | st;
        end
    end
endmodule

/* psm_fp_add.v */
/*
 * Combinational floating-point add, width set by parameters.
 * Assumes round to nearest even; denormal inputs read as zero and
 * tiny results flush to zero.
 */
`timescale 1ns/1ps
`include "psm_defines.vh"

module psm_fp_add #(
    parameter EW = 8,
    parameter MW = 23
)(
    input wire [EW+MW:0] a_in,
    input wire [EW+MW:0] b_in,
    output reg [EW+MW:0] s_out,
    output reg [`PSM_EXC_W-1:0] exc_out
);
    localparam N = MW + 4;
    localparam [EW-1:0] EMAX = {EW{1'h1}};
    localparam [EW+MW:0] QBIT = {{(EW+1){1'h0}}, 1'h1, {(MW-1){1'h0}}};
    localparam [EW+MW:0] DNAN = {1'h1, EMAX, 1'h1, {(MW-1){1'h0}}};
    wire sa = a_in[EW+MW];
    wire sb = b_in[EW+MW];
    wire [EW-1:0] ea = a_in[EW+MW-1:MW];
    wire [EW-1:0] eb = b_in[EW+MW-1:MW];
    wire [MW-1:0] fa = a_in[MW-1:0];
    wire [MW-1:0] fb = b_in[MW-1:0];
    wire nan_a = (ea == EMAX) && (fa != 0);
    wire nan_b = (eb == EMAX) && (fb != 0);
    wire inf_a = (ea == EMAX) && (fa == 0);
    wire inf_b = (eb == EMAX) && (fb == 0);
    wire zro_a = (ea == 0);
    wire zro_b = (eb == 0);
    wire den = (zro_a && (fa != 0)) || (zro_b && (fb != 0));
    wire snan = (nan_a && !fa[MW-1]) || (nan_b && !fb[MW-1]);
    wire a_big = {ea, fa} >= {eb, fb};
    wire s = a_big ? sa : sb;
    wire [EW-1:0] eh = a_big ? ea : eb;
    wire [EW-1:0] d = a_big ? (ea - eb) : (eb - ea);
    wire [N-1:0] mh = {1'h1, (a_big ? fa : fb), 3'h0};
    wire [N-1:0] ml = {1'h1, (a_big ? fb : fa), 3'h0};
    reg [N-1:0] mls;
    reg [N:0] sum;
    reg [MW+1:0] m;
    reg [EW+1:0] e;
    integer i;

    always @*
    begin
        // Align smaller operand, keep shifted-out bits as sticky
        mls = ml >> d;
        mls[0] = mls[0] | (|(ml & ~({N{1'h1}} << d)));
        if (sa ^ sb)
            sum = {1'h0, mh} - {1'h0, mls};
        else
            sum = {1'h0, mh} + {1'h0, mls};
        e = {2'h0, eh};
        if (sum[N])
        begin
            sum = {1'h0, sum[N:2], sum[1] | sum[0]};
            e = e + 1'h1;
        end
        else
        begin
            for (i = 0; i < N; i = i + 1)
            begin
                if (!sum[N-1] && (e != 0))
                begin
                    sum = sum << 1;
                    e = e - 1'h1;
                end
            end
        end
        m = {1'h0, sum[N-1:3]} + {{(MW+1){1'h0}}, sum[2] & (sum[1] | sum[0] | sum[3])};
        if (m[MW+1])
        begin
            m = m >> 1;
            e = e + 1'h1;
        end
        exc_out = {`PSM_EXC_W{1'h0}};
        exc_out[`PSM_EXC_DENORMAL] = den;
        if (nan_a || nan_b)
        begin
            s_out = nan_a ? (a_in | QBIT) : (b_in | QBIT);
            exc_out[`PSM_EXC_INVALID] = snan;
        end
        else if (inf_a && inf_b && (sa != sb))
        begin
            s_out = DNAN;
            exc_out[`PSM_EXC_INVALID] = 1'h1;
        end
        else if (inf_a)
            s_out = a_in;
        else if (inf_b)
            s_out = b_in;
        else if (zro_a && zro_b)
            s_out = {sa & sb, {(EW+MW){1'h0}}};
        else if (zro_a)
            s_out = b_in;
        else if (zro_b)
            s_out = a_in;
        else if (sum == 0)
            s_out = {(EW+MW+1){1'h0}};
        else if ((e == 0) || !sum[N-1])
        begin
            s_out = {s, {(EW+MW){1'h0}}};
            exc_out[`PSM_EXC_UNDERFLOW] = 1'h1;
            exc_out[`PSM_EXC_INEXACT] = 1'h1;
        end
        else if (e[EW:0] >= {1'h0, EMAX})
        begin
            s_out = {s, EMAX, {MW{1'h0}}};
            exc_out[`PSM_EXC_OVERFLOW] = 1'h1;
            exc_out[`PSM_EXC_INEXACT] = 1'h1;
        end
        else
        begin
            s_out = {s, e[EW-1:0], m[MW-1:0]};
            exc_out[`PSM_EXC_INEXACT] = |sum[2:0];
        end
    end
endmodule

/* psm_simd_top.v */
/*
 * Packed 128-bit datapath: dword multiplies, dot products, blends and
 * integer min/max, one result per accepted operation.
 * Assumes operands come from decode and register file on the same clock;
 * one operation per cycle, result one cycle later.
 */
`timescale 1ns/1ps
`include "psm_defines.vh"

module psm_simd_top (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire op_valid_in,
    input wire [`PSM_OP_W-1:0] op_code_in,
    input wire [7:0] op_imm_in,
    input wire [127:0] op_dst_in,
    input wire [127:0] op_src_in,
    input wire [127:0] implicit_vector_reg_zero_in,
    input wire [`PSM_EXC_W-1:0] exc_mask_in,
    output reg res_valid_out,
    output reg [127:0] res_data_out,
    output reg res_write_out,
    output reg [`PSM_EXC_W-1:0] res_exc_out,
    output reg res_fault_out
);
    wire [127:0] dst = op_dst_in;
    wire [127:0] src = op_src_in;
    wire [7:0] imm = op_imm_in;
    wire [127:0] ctl = implicit_vector_reg_zero_in;

    wire [127:0] mul_lo;
    wire [127:0] mul_ws;
    wire [127:0] mul_wu;
    wire [127:0] min_sb;
    wire [127:0] max_sb;
    wire [127:0] min_uw;
    wire [127:0] max_uw;
    wire [127:0] min_ud;
    wire [127:0] max_ud;
    wire [127:0] min_sd;
    wire [127:0] max_sd;
    wire [15:0] bsel;
    wire [127:0] blend;
    wire [127:0] sp;
    wire [19:0] sp_exc;
    wire [31:0] s01;
    wire [31:0] s23;
    wire [31:0] ssum;
    wire [`PSM_EXC_W-1:0] sa0_exc;
    wire [`PSM_EXC_W-1:0] sa1_exc;
    wire [`PSM_EXC_W-1:0] sa2_exc;
    wire [127:0] dps;
    wire [127:0] dp;
    wire [9:0] dp_exc;
    wire [63:0] dsum;
    wire [`PSM_EXC_W-1:0] da_exc;
    wire [127:0] dpd;
    wire [`PSM_EXC_W-1:0] dps_exc;
    wire [`PSM_EXC_W-1:0] dpd_exc;

    reg [127:0] data_next;
    reg write_next;
    reg [`PSM_EXC_W-1:0] exc_next;
    reg fault_next;

    genvar k;

    // Dword lanes: low multiply and dword min/max
    generate
        for (k = 0; k < 4; k = k + 1)
        begin : g_dw
            wire [31:0] x = dst[32*k+31:32*k];
            wire [31:0] y = src[32*k+31:32*k];
            wire signed [63:0] ps = $signed(x) * $signed(y);
            wire lt_u = x < y;
            wire lt_s = $signed(x) < $signed(y);
            assign mul_lo[32*k+31:32*k] = ps[31:0];
            assign min_ud[32*k+31:32*k] = lt_u ? x : y;
            assign max_ud[32*k+31:32*k] = lt_u ? y : x;
            assign min_sd[32*k+31:32*k] = lt_s ? x : y;
            assign max_sd[32*k+31:32*k] = lt_s ? y : x;
        end
    endgenerate

    // Widening multiplies use the even dword of each qword
    generate
        for (k = 0; k < 2; k = k + 1)
        begin : g_qw
            wire [31:0] x = dst[64*k+31:64*k];
            wire [31:0] y = src[64*k+31:64*k];
            wire signed [63:0] ws = $signed(x) * $signed(y);
            wire [63:0] wu = x * y;
            assign mul_ws[64*k+63:64*k] = ws;
            assign mul_wu[64*k+63:64*k] = wu;
        end
    endgenerate

    // Word lanes, unsigned
    generate
        for (k = 0; k < 8; k = k + 1)
        begin : g_w
            wire [15:0] x = dst[16*k+15:16*k];
            wire [15:0] y = src[16*k+15:16*k];
            wire lt = x < y;
            assign min_uw[16*k+15:16*k] = lt ? x : y;
            assign max_uw[16*k+15:16*k] = lt ? y : x;
        end
    endgenerate

    // Byte lanes: signed min/max and blend byte select
    generate
        for (k = 0; k < 16; k = k + 1)
        begin : g_b
            wire [7:0] x = dst[8*k+7:8*k];
            wire [7:0] y = src[8*k+7:8*k];
            wire lt = $signed(x) < $signed(y);
            reg sel;
            assign min_sb[8*k+7:8*k] = lt ? x : y;
            assign max_sb[8*k+7:8*k] = lt ? y : x;
            always @*
            begin
                case (op_code_in)
                    `PSM_OP_BLEND_SINGLE_BY_IMMEDIATE: sel = imm[k/4];
                    `PSM_OP_BLEND_DOUBLE_BY_IMMEDIATE: sel = imm[k/8];
                    `PSM_OP_BLEND_WORD_BY_IMMEDIATE: sel = imm[k/2];
                    `PSM_OP_BLEND_SINGLE_BY_REGISTER: sel = ctl[32*(k/4)+31];
                    `PSM_OP_BLEND_DOUBLE_BY_REGISTER: sel = ctl[64*(k/8)+63];
                    `PSM_OP_BLEND_BYTE_BY_REGISTER: sel = ctl[8*k+7];
                    default: sel = 1'h0;
                endcase
            end
            assign bsel[k] = sel;
            assign blend[8*k+7:8*k] = sel ? y : x;
        end
    endgenerate

    // Single dot product: four selected products, pairwise sums
    generate
        for (k = 0; k < 4; k = k + 1)
        begin : g_sm
            psm_fp_mul #(
                .EW(8),
                .MW(23)
            ) u_mul (
                .a_in(imm[4+k] ? dst[32*k+31:32*k] : 32'h0),
                .b_in(imm[4+k] ? src[32*k+31:32*k] : 32'h0),
                .p_out(sp[32*k+31:32*k]),
                .exc_out(sp_exc[5*k+4:5*k])
            );
            assign dps[32*k+31:32*k] = imm[k] ? ssum : 32'h0;
        end
    endgenerate

    psm_fp_add #(
        .EW(8),
        .MW(23)
    ) u_sadd0 (
        .a_in(sp[31:0]),
        .b_in(sp[63:32]),
        .s_out(s01),
        .exc_out(sa0_exc)
    );

    psm_fp_add #(
        .EW(8),
        .MW(23)
    ) u_sadd1 (
        .a_in(sp[95:64]),
        .b_in(sp[127:96]),
        .s_out(s23),
        .exc_out(sa1_exc)
    );

    psm_fp_add #(
        .EW(8),
        .MW(23)
    ) u_sadd2 (
        .a_in(s01),
        .b_in(s23),
        .s_out(ssum),
        .exc_out(sa2_exc)
    );

    assign dps_exc = sp_exc[4:0] | sp_exc[9:5] | sp_exc[14:10] | sp_exc[19:15]
                     | sa0_exc | sa1_exc | sa2_exc;

    // Double dot product: two selected products, one sum
    generate
        for (k = 0; k < 2; k = k + 1)
        begin : g_dm
            psm_fp_mul #(
                .EW(11),
                .MW(52)
            ) u_mul (
                .a_in(imm[4+k] ? dst[64*k+63:64*k] : 64'h0),
                .b_in(imm[4+k] ? src[64*k+63:64*k] : 64'h0),
                .p_out(dp[64*k+63:64*k]),
                .exc_out(dp_exc[5*k+4:5*k])
            );
            assign dpd[64*k+63:64*k] = imm[k] ? dsum : 64'h0;
        end
    endgenerate

    psm_fp_add #(
        .EW(11),
        .MW(52)
    ) u_dadd (
        .a_in(dp[63:0]),
        .b_in(dp[127:64]),
        .s_out(dsum),
        .exc_out(da_exc)
    );

    assign dpd_exc = dp_exc[4:0] | dp_exc[9:5] | da_exc;

    // Result select
    always @*
    begin
        data_next = dst;
        write_next = 1'h1;
        exc_next = {`PSM_EXC_W{1'h0}};
        fault_next = 1'h0;
        case (op_code_in)
            `PSM_OP_MUL_SIGNED_LOW_DWORD: data_next = mul_lo;
            `PSM_OP_MUL_SIGNED_WIDE_DWORD: data_next = mul_ws;
            `PSM_OP_MUL_UNSIGNED_WIDE_DWORD: data_next = mul_wu;
            `PSM_OP_DOT_PRODUCT_SINGLE:
            begin
                exc_next = dps_exc;
                fault_next = |(dps_exc & ~exc_mask_in);
                data_next = fault_next ? dst : dps;
                write_next = !fault_next;
            end
            `PSM_OP_DOT_PRODUCT_DOUBLE:
            begin
                exc_next = dpd_exc;
                fault_next = |(dpd_exc & ~exc_mask_in);
                data_next = fault_next ? dst : dpd;
                write_next = !fault_next;
            end
            `PSM_OP_BLEND_SINGLE_BY_IMMEDIATE,
            `PSM_OP_BLEND_DOUBLE_BY_IMMEDIATE,
            `PSM_OP_BLEND_WORD_BY_IMMEDIATE,
            `PSM_OP_BLEND_SINGLE_BY_REGISTER,
            `PSM_OP_BLEND_DOUBLE_BY_REGISTER,
            `PSM_OP_BLEND_BYTE_BY_REGISTER: data_next = blend;
            `PSM_OP_MIN_UNSIGNED_WORD: data_next = min_uw;
            `PSM_OP_MIN_UNSIGNED_DWORD: data_next = min_ud;
            `PSM_OP_MIN_SIGNED_BYTE: data_next = min_sb;
            `PSM_OP_MIN_SIGNED_DWORD: data_next = min_sd;
            `PSM_OP_MAX_UNSIGNED_WORD: data_next = max_uw;
            `PSM_OP_MAX_UNSIGNED_DWORD: data_next = max_ud;
            `PSM_OP_MAX_SIGNED_BYTE: data_next = max_sb;
            `PSM_OP_MAX_SIGNED_DWORD: data_next = max_sd;
            default: write_next = 1'h0;
        endcase
    end

    // Result register, one cycle after acceptance
    always @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            res_valid_out <= 1'h0;
            res_data_out <= 128'h0;
            res_write_out <= 1'h0;
            res_exc_out <= {`PSM_EXC_W{1'h0}};
            res_fault_out <= 1'h0;
        end
        else
        begin
            res_valid_out <= op_valid_in;
            if (op_valid_in)
            begin
                res_data_out <= data_next;
                res_write_out <= write_next;
                res_exc_out <= exc_next;
                res_fault_out <= fault_next;
            end
            else
            begin
                res_write_out <= 1'h0;
                res_fault_out <= 1'h0;
            end
        end
    end
endmodule

/* psm_simd_asserts.sv */
/*
 * Checker for the packed datapath top: timing of the result pulse,
 * held outputs, fault handling and one lane of several operations.
 * Assumes binding to psm_simd_top and one clock domain.
 */
`timescale 1ns/1ps
`include "psm_defines.vh"

module psm_simd_asserts (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire op_valid_in,
    input wire [`PSM_OP_W-1:0] op_code_in,
    input wire [7:0] op_imm_in,
    input wire [127:0] op_dst_in,
    input wire [127:0] op_src_in,
    input wire [127:0] implicit_vector_reg_zero_in,
    input wire [`PSM_EXC_W-1:0] exc_mask_in,
    input wire res_valid_out,
    input wire [127:0] res_data_out,
    input wire res_write_out,
    input wire [`PSM_EXC_W-1:0] res_exc_out,
    input wire res_fault_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    logic [127:0] d_q;
    logic [127:0] s_q;
    logic [127:0] z_q;
    logic [7:0] i_q;
    // Operands of the previous edge
    always_ff @(posedge core_clk_in)
    begin
        d_q <= op_dst_in;
        s_q <= op_src_in;
        z_q <= implicit_vector_reg_zero_in;
        i_q <= op_imm_in;
    end
    chk_valid_answer_next:
        assert property (op_valid_in |=> res_valid_out) else $error("result missing after request");
    chk_no_idle_pulse:
        assert property (!op_valid_in |=> !res_valid_out && !res_write_out && !res_fault_out)
        else $error("result pulse without request");
    chk_result_holds:
        assert property (!op_valid_in |=> $stable(res_data_out) && $stable(res_exc_out))
        else $error("result changed while idle");
    chk_fault_no_write:
        assert property (res_fault_out |-> res_valid_out && !res_write_out) else $error("fault with write");
    chk_fault_keeps_dst:
        assert property (op_valid_in ##1 res_fault_out |-> res_data_out == d_q) else $error("fault changed data");
    chk_exc_dot_only:
        assert property (op_valid_in && op_code_in != `PSM_OP_DOT_PRODUCT_SINGLE
            && op_code_in != `PSM_OP_DOT_PRODUCT_DOUBLE |=> res_exc_out == 5'h00 && !res_fault_out)
        else $error("flags on integer op");
    chk_mul_low_lane:
        assert property (op_valid_in && op_code_in == `PSM_OP_MUL_SIGNED_LOW_DWORD
            |=> res_data_out[63:32] == 32'(d_q[63:32] * s_q[63:32])) else $error("low multiply lane 1");
    chk_blend_imm_lane:
        assert property (op_valid_in && op_code_in == `PSM_OP_BLEND_SINGLE_BY_IMMEDIATE
            |=> res_data_out[127:96] == (i_q[3] ? s_q[127:96] : d_q[127:96])) else $error("blend lane 3");
    chk_blendv_byte_sel:
        assert property (op_valid_in && op_code_in == `PSM_OP_BLEND_BYTE_BY_REGISTER
            |=> res_data_out[15:8] == (z_q[15] ? s_q[15:8] : d_q[15:8])) else $error("byte blend lane 1");
    chk_max_udword_lane:
        assert property (op_valid_in && op_code_in == `PSM_OP_MAX_UNSIGNED_DWORD
            |=> res_data_out[31:0] == (d_q[31:0] > s_q[31:0] ? d_q[31:0] : s_q[31:0]))
        else $error("unsigned max lane 0");
endmodule

bind psm_simd_top psm_simd_asserts u_chk (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .op_valid_in(op_valid_in),
    .op_code_in(op_code_in),
    .op_imm_in(op_imm_in),
    .op_dst_in(op_dst_in),
    .op_src_in(op_src_in),
    .implicit_vector_reg_zero_in(implicit_vector_reg_zero_in),
    .exc_mask_in(exc_mask_in),
    .res_valid_out(res_valid_out),
    .res_data_out(res_data_out),
    .res_write_out(res_write_out),
    .res_exc_out(res_exc_out),
    .res_fault_out(res_fault_out)
);

/* psm_decode_model.sv */
/*
 * Model of decode and register file feeding the datapath.
 * Assumes the bench calls put and idle; drives at the falling edge.
 */
`timescale 1ns/1ps

module psm_decode_model (
    input wire core_clk_in,
    output logic op_valid_out,
    output logic [4:0] op_code_out,
    output logic [7:0] op_imm_out,
    output logic [127:0] op_dst_out,
    output logic [127:0] op_src_out,
    output logic [127:0] ctl_out,
    output logic [4:0] exc_mask_out
);
    initial
    begin
        op_valid_out = 1'b0;
        op_code_out = 5'h00;
        op_imm_out = 8'h00;
        op_dst_out = 128'h0;
        op_src_out = 128'h0;
        ctl_out = 128'h0;
        exc_mask_out = 5'h00;
    end
    // One request, held high when called back to back
    task automatic put(input logic [4:0] c, input logic [7:0] i, input logic [127:0] d, s, z, input logic [4:0] m);
        @(negedge core_clk_in);
        op_valid_out = 1'b1;
        op_code_out = c;
        op_imm_out = i;
        op_dst_out = d;
        op_src_out = s;
        ctl_out = z;
        exc_mask_out = m;
    endtask
    // Released operands toggle every cycle
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge core_clk_in);
            op_valid_out = 1'b0;
            op_code_out = ~op_code_out;
            op_imm_out = ~op_imm_out;
            op_dst_out = ~op_dst_out;
            op_src_out = ~op_src_out;
            ctl_out = ~ctl_out;
        end
    endtask
endmodule

/* packed_simd_mul_blend_minmax_bench.sv */
/*
 * Self-checking bench for the packed datapath: multiplies, blends,
 * min/max, dot products with fault and masking.
 * Assumes the decode model drives all operation inputs.
 */
`timescale 1ns/1ps
`include "psm_defines.vh"

module packed_simd_mul_blend_minmax_bench;
    logic core_clk_in;
    logic arst_n_in;
    wire v, rv, rw, rf;
    wire [4:0] c, m, re;
    wire [7:0] im;
    wire [127:0] d, s, z, rd;
    int err_count, checked;
    logic [127:0] last;
    localparam logic [127:0] A = 128'h80FF7F01_FFFF0001_7FFFFFFF_80000000;
    localparam logic [127:0] B = 128'h7F0180FF_0001FFFF_80000000_7FFFFFFF;
    localparam logic [127:0] Z = 128'h80FF0080_00000000_7F808000_00000001;

    psm_decode_model u_drv (.core_clk_in(core_clk_in), .op_valid_out(v), .op_code_out(c), .op_imm_out(im),
        .op_dst_out(d), .op_src_out(s), .ctl_out(z), .exc_mask_out(m));
    psm_simd_top u_dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .op_valid_in(v), .op_code_in(c),
        .op_imm_in(im), .op_dst_in(d), .op_src_in(s), .implicit_vector_reg_zero_in(z), .exc_mask_in(m),
        .res_valid_out(rv), .res_data_out(rd), .res_write_out(rw), .res_exc_out(re), .res_fault_out(rf));

    initial
    begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input logic [127:0] g, e);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic run(input logic [4:0] oc, input logic [7:0] i, input logic [127:0] dd, ss, zz,
        input logic [4:0] mm, input logic [127:0] ed, input logic ew, input logic [4:0] ee, input logic ef);
        u_drv.put(oc, i, dd, ss, zz, mm);
        repeat (`PSM_LATENCY) @(posedge core_clk_in);
        #1;
        chk(rv, 1'b1);
        chk(rw, ew);
        chk(re, ee);
        chk(rf, ef);
        chk(rd, ed);
        last = rd;
    endtask

    // Idle cycle: no pulse, result held
    task automatic quiet;
        u_drv.idle(1);
        repeat (`PSM_LATENCY) @(posedge core_clk_in);
        #1;
        chk(rv, 1'b0);
        chk(rd, last);
    endtask

    function automatic logic [127:0] mul_exp(input logic [4:0] oc, input logic [127:0] a, b);
        logic [127:0] r;
        longint x, y;
        for (int i = 0; i < 4; i++)
            r[32*i+:32] = a[32*i+:32] * b[32*i+:32];
        for (int i = 0; i < 2 && oc != `PSM_OP_MUL_SIGNED_LOW_DWORD; i++)
        begin
            x = (oc == `PSM_OP_MUL_SIGNED_WIDE_DWORD) ? longint'($signed(a[64*i+:32])) : longint'(a[64*i+:32]);
            y = (oc == `PSM_OP_MUL_SIGNED_WIDE_DWORD) ? longint'($signed(b[64*i+:32])) : longint'(b[64*i+:32]);
            r[64*i+:64] = x * y;
        end
        return r;
    endfunction

    function automatic logic [127:0] blend_exp(input logic [4:0] oc, input logic [7:0] i, input logic [127:0] a, b, k);
        int e;
        bit sel;
        logic [127:0] mk;
        logic [127:0] r;
        e = (oc == 5'h06 || oc == 5'h09) ? 64 : (oc == 5'h07) ? 16 : (oc == 5'h0A) ? 8 : 32;
        mk = (128'h1 << e) - 1;
        r = 128'h0;
        for (int n = 0; n < 128 / e; n++)
        begin
            sel = (oc >= `PSM_OP_BLEND_SINGLE_BY_REGISTER) ? k[n*e+e-1] : i[n];
            r |= (((sel ? b : a) >> (n * e)) & mk) << (n * e);
        end
        return r;
    endfunction

    function automatic logic [127:0] mm_exp(input logic [4:0] oc, input logic [127:0] a, b);
        int k;
        int e;
        bit mx;
        logic [31:0] x, y, mk, f;
        logic [127:0] r;
        mx = oc >= `PSM_OP_MAX_UNSIGNED_WORD;
        k = mx ? oc - `PSM_OP_MAX_UNSIGNED_WORD : oc - `PSM_OP_MIN_UNSIGNED_WORD;
        e = (k == 0) ? 16 : (k == 2) ? 8 : 32;
        mk = (e == 32) ? 32'hFFFFFFFF : (32'h1 << e) - 1;
        f = (k >= 2) ? 32'h1 << (e - 1) : 32'h0;
        r = 128'h0;
        for (int n = 0; n < 128 / e; n++)
        begin
            x = 32'(a >> (n * e)) & mk;
            y = 32'(b >> (n * e)) & mk;
            r |= 128'((((x ^ f) > (y ^ f)) == mx) ? x : y) << (n * e);
        end
        return r;
    endfunction

    task automatic t_mul;
        for (int oc = 0; oc < 3; oc++)
            run(5'(oc), 8'h00, A, B, Z, 5'h00, mul_exp(5'(oc), A, B), 1, 5'h00, 0);
        quiet();
        $display("test mul done");
    endtask

    task automatic t_blend;
        for (int oc = 5; oc < 11; oc++)
            run(5'(oc), 8'hA5, A, B, Z, 5'h00, blend_exp(5'(oc), 8'hA5, A, B, Z), 1, 5'h00, 0);
        quiet();
        $display("test blend done");
    endtask

    task automatic t_minmax;
        for (int oc = 11; oc < 19; oc++)
            run(5'(oc), 8'h00, A, B, Z, 5'h00, mm_exp(5'(oc), A, B), 1, 5'h00, 0);
        run(5'h1F, 8'h00, A, B, Z, 5'h00, A, 0, 5'h00, 0);
        quiet();
        $display("test minmax done");
    endtask

    task automatic t_dot;
        logic [127:0] o, inf;
        o = {4{32'h3F800000}};
        inf = 128'h3F800000_3F800000_3F800000_7F800000;
        run(5'h03, 8'hF1, 128'h40800000_40400000_40000000_3F800000, o, Z, 5'h00,
            128'h41200000, 1, 5'h00, 0);
        run(5'h03, 8'hD2, 128'h40800000_40400000_7F800001_3F800000, o, Z, 5'h00,
            128'h41000000_00000000, 1, 5'h00, 0);
        run(5'h04, 8'h31, 128'h40080000_00000000_40000000_00000000, 128'h40140000_00000000_40100000_00000000,
            Z, 5'h00, 128'h40370000_00000000, 1, 5'h00, 0);
        run(5'h04, 8'h12, 128'h40080000_00000000_40000000_00000000, 128'h40140000_00000000_40100000_00000000,
            Z, 5'h00, 128'h40200000_00000000_00000000_00000000, 1, 5'h00, 0);
        run(5'h03, 8'h11, inf, 128'h0, Z, 5'h00, inf, 0, 5'h01, 1);
        run(5'h03, 8'h11, inf, 128'h0, Z, 5'h1F, 128'hFFC00000, 1, 5'h01, 0);
        quiet();
        $display("test dot done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #4000;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        err_count = 0;
        checked = 0;
        last = 128'h0;
        arst_n_in = 1'b0;
        repeat (8) @(negedge core_clk_in);
        arst_n_in = 1'b1;
        t_mul();
        t_blend();
        t_minmax();
        t_dot();
        @(negedge core_clk_in) arst_n_in = 1'b0;
        #1 chk({rv, rw, rf, re}, 128'h0);
        chk(rd, 128'h0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
